// >>> test/evt_source_model.sv
// Purpose: translation datapath model issuing counted events
// Assumes: events are one-cycle pulses on the design clock
// Notes:   between events the id and identifier flip so stale values never match
`timescale 1ns/100ps
`default_nettype none
`include "sid_filter_defines.svh"
module evt_source_model (
    input wire logic                   core_clk,
    output logic                       evtValid,
    output logic [`EVT_W-1:0]          evtId,
    output logic [`FULL_SID_W-1:0]     evtSid,
    output logic                       evtSecure,
    output logic                       evtSidRelated,
    output logic                       evtTerminated,
    output logic                       evtSpecul,
    output logic                       evtAtop,
    output logic                       evtCmaint,
    output logic                       evtRetry,
    output logic                       evtCombinedMiss
);
    initial begin
        evtValid = 1'b0;
        evtId = 4'h0;
        evtSid = 24'h0;
        {evtSecure, evtSidRelated, evtTerminated, evtSpecul} = 4'h0;
        {evtAtop, evtCmaint, evtRetry, evtCombinedMiss} = 4'h0;
    end
    // one event per call; calls back to back give one event per cycle
    task automatic send(input logic [3:0] id, input logic [23:0] sid, input logic [7:0] f);
        @(posedge core_clk);
        evtValid <= 1'b1;
        evtId <= id;
        evtSid <= sid;
        {evtSecure, evtSidRelated, evtTerminated, evtSpecul} <= f[7:4];
        {evtAtop, evtCmaint, evtRetry, evtCombinedMiss} <= f[3:0];
    endtask : send
    task automatic idle;
        @(posedge core_clk);
        evtValid <= 1'b0;
        evtId <= ~evtId;
        evtSid <= ~evtSid;
    endtask : idle
endmodule : evt_source_model
`default_nettype wire

// >>> test/perf_counter_stream_filter_checker.sv
// Purpose: bus protocol checks on the counter group ports
// Assumes: bound to the design top, one clock domain
// Notes:   event counting is judged by the bench model
`timescale 1ns/100ps
`default_nettype none
module perf_counter_stream_filter_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // write steps: both halves taken, then the answer handshake
    sequence wrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence bDone;
        s_axi_bvalid && s_axi_bready;
    endsequence
    a_write_answer: assert property (wrBoth |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles after take");
    a_ready_back: assert property (bDone |=> !s_axi_awready ##1 s_axi_awready)
        else $error("write address ready not back one cycle after answer");
    a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address accepted too early");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before handshake");
    // reads answer one cycle later and hold until taken
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before handshake");
    a_ar_hold: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while answer pending");
    a_reset_idle: assert property ($fell(rst)
        |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");
endmodule : perf_counter_stream_filter_checker
`default_nettype wire

// >>> test/tb_perf_counter_stream_filter.sv
// Purpose: self-checking bench for the stream filtered counters
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes:   reference model in plain arrays, compared at every read
`timescale 1ns/100ps
`default_nettype none
`include "sid_filter_defines.svh"
module tb_perf_counter_stream_filter;
    logic core_clk = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic evtValid, evtSecure, evtSidRelated, evtTerminated, evtSpecul;
    logic evtAtop, evtCmaint, evtRetry, evtCombinedMiss;
    logic [3:0] evtId, id;
    logic [23:0] evtSid, sid;
    logic [31:0] v, d, ctr[4];
    logic [7:0] f;
    int failures = 0, n_compared = 0, cyc = 0, seed = 41;
    // filter set-up: exact, partial span, all ones, top-zero mask
    logic [3:0] typ[4] = '{4'h1, 4'h2, 4'h3, 4'h2};
    bit spn[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    bit sec[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [31:0] mvw[4] = '{32'h00011b75, 32'h1b77, 32'h0fffffff, 32'h7fff};
    logic [31:0] ctlv[3] = '{32'h0, 32'h3, 32'h1};
    logic [3:0] ids[4] = '{4'h1, 4'h2, 4'h3, 4'h7};
    bit en, secObs;
    perf_counter_stream_filter uut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .evtValid, .evtId, .evtSid, .evtSecure, .evtSidRelated, .evtTerminated,
        .evtSpecul, .evtAtop, .evtCmaint, .evtRetry, .evtCombinedMiss);
    evt_source_model ev (.core_clk, .evtValid, .evtId, .evtSid, .evtSecure, .evtSidRelated,
        .evtTerminated, .evtSpecul, .evtAtop, .evtCmaint, .evtRetry, .evtCombinedMiss);
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // does event land in counter i; filter entries are per counter (capability 0)
    function automatic bit hit(int i, logic [3:0] e, logic [23:0] s, logic [7:0] g);
        logic [15:0] ign;
        if (!en) return 0;
        if (!(e == typ[i] || (g[0] && e inside {2, 3} && typ[i] inside {2, 3}))) return 0;
        if (g[3] || g[2]) return 0;
        if (!g[6]) return 1;
        ign = spn[i] ? (mvw[i][15:0] ^ (mvw[i][15:0] + 16'h1)) : 16'h0;
        if (spn[i] && mvw[i][15:0] == 16'hffff) return !g[7] || secObs;
        if (g[7] != (sec[i] & secObs)) return 0;
        return ((s[15:0] ^ mvw[i][15:0]) & ~ign) == 16'h0;
    endfunction : hit
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // bus master: valid held until ready, answer ready raised once answer seen
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= s_axi_bvalid;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= s_axi_rvalid;
        end
        dat = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // cut a hang short; the run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            rd(`OFF_CTR_BASE + 12'(4 * i), d, r);
            chk(d, 32'h0);
            rd(`OFF_SMR_BASE + 12'(4 * i), d, r);
            chk(d, 32'h0);
        end
        rd(`OFF_CAP, d, r);
        chk(d, 32'h0);
        wr(12'he08, 32'h1, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        rd(12'he08, d, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        $display("test reset and map done");
        for (int i = 0; i < 4; i++) begin
            wr(`OFF_EVT_BASE + 12'(4 * i), {1'b0, sec[i], spn[i], 25'h0, typ[i]}, r);
            wr(`OFF_SMR_BASE + 12'(4 * i), mvw[i], r);
            chk({30'h0, r}, {30'h0, `RESP_OKAY});
            ctr[i] = 32'h0;
        end
        rd(`OFF_SMR_BASE, d, r);
        chk(d, 32'h00001b75);
        rd(`OFF_SMR_BASE + 12'h8, d, r);
        chk(d, 32'h0000ffff);
        ctr[1] = 32'hffffff00;
        wr(`OFF_CTR_BASE + 12'h4, ctr[1], r);
        foreach (ctlv[b]) begin
            wr(`OFF_CTRL, ctlv[b], r);
            en = ctlv[b][0];
            secObs = ctlv[b][1];
            repeat (150) begin
                v = $random(seed);
                id = ids[v[13:12]];
                sid = v[0] ? {v[31:24], 12'h1b7, v[11:8]} : v[23:0];
                f = {v[14], v[15] | v[16], v[17], v[18], v[19] & v[20], v[21] & v[22], v[23],
                     v[25] & (id == 4'h2 || id == 4'h3)};
                ev.send(id, sid, f);
                for (int i = 0; i < 4; i++) if (hit(i, id, sid, f)) ctr[i]++;
                if (v[26] & v[27]) ev.idle();
            end
            ev.idle();
            for (int i = 0; i < 4; i++) begin
                rd(`OFF_CTR_BASE + 12'(4 * i), d, r);
                chk(d, ctr[i]);
            end
            $display("test batch %0d done", b);
        end
        end_sim();
    end
endmodule : tb_perf_counter_stream_filter
bind perf_counter_stream_filter perf_counter_stream_filter_checker chk_i (.core_clk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// >>> verilog/perf_counter_stream_filter.sv
// Purpose: stream filtered event counters of one counter group
// Assumes: events arrive as one-cycle pulses from the translation datapath
// Notes:   registers reached over AXI4-Lite; no overflow or interrupt logic
//          counters are 32 bits and wrap; filter type is fixed per counter
//          local identifier is 16 bits, the low slice of the full one
//
// How it works
// - terminated traffic counted alike in events 1,2,3,7
// - speculative/atop/cmaint choices equal across events 1-3
// - retries recount fully or not at all
// - mandatory events countable for every stream used
// - combined cache miss bumps both miss events
// - no table walker, walk events not counted
// - stream-free events ignore the filter
// - capability 0: counter uses own filter entries
// - capability 1: counter 0 filter governs all
// - span 0 needs exact identifier match
// - span 1 ignores bits up to and including lowest clear bit
// - span 1 with all ones matches any
// - all ones spans both namespaces if observing secure
// - top-zero mask matches all in selected namespace
// - namespace flag picks space; no observation forces non-secure
// - local identifier is low bits of full one
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sid_filter_defines.svh"
module perf_counter_stream_filter
    import sid_filter_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst,

    // write address, data and response channels
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,

    // read address and data channels
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,

    // one event per cycle at most, same clock as the bus
    input  wire logic                   evtValid,
    input  wire logic [`EVT_W-1:0]      evtId,
    input  wire logic [`FULL_SID_W-1:0] evtSid,
    input  wire logic                   evtSecure,
    input  wire logic                   evtSidRelated,
    // category flags, weighed against the fixed counting choices
    input  wire logic                   evtTerminated,
    input  wire logic                   evtSpecul,
    input  wire logic                   evtAtop,
    input  wire logic                   evtCmaint,
    input  wire logic                   evtRetry,
    input  wire logic                   evtCombinedMiss
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    // every flop of the block lives in this one struct
    state_t state_q;
    state_t state_d;

    // per-counter verdict on the event of this cycle
    logic [`NUM_CTR-1:0] hit;
    // identifier bits above the local width never reach a filter
    logic [`SID_W-1:0]   localSid;
    // event passes enable and the category switches
    logic                qualOk;

    // local identifier is the low slice of the full one
    assign localSid = evtSid[`SID_W-1:0];

    // global qualification of the event by category
    // the switches are fixed at build time, so most of this folds away;
    // keeping them as code lets a variant flip one define and stay consistent
    always_comb begin
        // the enable gates stream-free events as well
        qualOk = evtValid & state_q.enable;
        // one switch per category, shared by events 1,2,3 and 7
        if (evtTerminated && !`COUNT_TERMINATED) qualOk = 1'b0;
        if (evtSpecul && !`COUNT_SPECUL) qualOk = 1'b0;
        if (evtAtop && !`COUNT_ATOP) qualOk = 1'b0;
        if (evtCmaint && !`COUNT_CMAINT) qualOk = 1'b0;
        // a retry is either a full new event or invisible
        if (evtRetry && !`RECOUNT_RETRY) qualOk = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-counter filter

    // one filter per counter; with a shared filter all of them read entry 0
    // and the unused entries are left for synthesis to prune
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CTR; gi++) begin : g_filt
            // entry that feeds this counter's filter
            localparam int SRC = `FILTER_SHARED ? 0 : gi;
            logic [`SID_W-1:0] mv;
            logic [`SID_W-1:0] careMask;
            logic              sp;
            logic              sec;
            logic              allOnes;
            logic              sidOk;
            logic              nsOk;
            logic              typeOk;

            // shared capability routes counter 0 entries to all
            assign mv = state_q.matchVal[SRC];
            assign sp = state_q.span[SRC];
            // without secure observation the flag is overridden
            assign sec = state_q.secSel[SRC] & state_q.secObs;
            // with span set, all ones is the match-any code and, when observing secure, also widens the namespace
            assign allOnes = &mv;
            // mask clears trailing ones plus the first zero above them
            assign careMask = sp ? ~(mv ^ (mv + `SID_W'(1))) : {`SID_W{1'b1}};
            // exact compare when span is off, upper bits when on
            assign sidOk = sp && allOnes ? 1'b1
                         : ((localSid & careMask) == (mv & careMask));
            // all ones with span set widens scope to both spaces when observing secure
            assign nsOk = (sp && allOnes) ? (state_q.secObs | ~evtSecure)
                        : (evtSecure == sec);

            // combined cache miss counts as events 2 and 3; one miss is
            // both a configuration and a translation miss, never two events
            assign typeOk = (evtId == state_q.evtId[gi])
                          | (`COMBINED_CACHE & evtCombinedMiss
                             & ((state_q.evtId[gi] == `EVT_W'(2))
                                | (state_q.evtId[gi] == `EVT_W'(3))));

            // stream-free events pass regardless of filter
            // a stream-tied event must pass both the identifier and the space
            assign hit[gi] = qualOk & typeOk
                           & (~evtSidRelated | (sidOk & nsOk));
        end
    endgenerate
    // this group has filters for every local identifier, all events
    // walk events 4 and 5 only pulse if the datapath owns a walker
    // limitation: identifiers above the local width are not compared, so a
    // group must only ever see traffic from its own slice of the id space

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // scratch values of the decode, all set at the top of the process
    logic [11:0] wa;
    logic [11:0] ra;
    logic [31:0] rd;
    logic        rOk;
    logic        wOk;
    logic [31:0] wv;

    always_comb begin
        state_d = state_q;
        wa = 12'h000;
        ra = 12'h000;
        rd = 32'h0000_0000;
        rOk = 1'b0;
        wOk = 1'b0;
        wv = 32'h0000_0000;

        // counters step one cycle after a passing event
        // no saturation: a counter wraps silently, overflow is not tracked
        for (int i = 0; i < `NUM_CTR; i++) begin
            if (hit[i]) state_d.ctr[i] = state_q.ctr[i] + `CTR_W'(1);
        end

        // write address and data taken independently; each ready drops on
        // its own take and stays low until the response has gone out, which
        // keeps a second write from overtaking the first
        if (s_axi_awvalid && state_q.awready) begin
            state_d.awTaken = 1'b1;
            state_d.awAddr = s_axi_awaddr;
            state_d.awready = 1'b0;
        end

        // data half, with its byte strobes
        if (s_axi_wvalid && state_q.wready) begin
            state_d.wTaken = 1'b1;
            state_d.wData = s_axi_wdata;
            state_d.wStrb = s_axi_wstrb;
            state_d.wready = 1'b0;
        end

        // write decode runs one cycle after the later half was taken, so
        // the address compare sees registered values only
        case (state_q.wrSt)
            WR_IDLE: begin
                if (state_q.awTaken && state_q.wTaken) begin
                    wa = state_q.awAddr;
                    wv = state_q.wData;
                    // strobe-off bytes are written as zero, not merged
                    for (int b = 0; b < 4; b++) begin
                        if (!state_q.wStrb[b]) wv[b*8 +: 8] = 8'h00;
                    end
                    for (int i = 0; i < `NUM_CTR; i++) begin
                        // counter words
                        if (wa == `OFF_CTR_BASE + 12'(i*4)) begin
                            state_d.ctr[i] = wv; // software write beats a step
                            wOk = 1'b1;
                        end
                        // event type word: id, span and namespace flags
                        if (wa == `OFF_EVT_BASE + 12'(i*4)) begin
                            state_d.evtId[i] = wv[`EVT_ID_LSB +: `EVT_W];
                            state_d.span[i] = wv[`EVT_SPAN_BIT];
                            state_d.secSel[i] = wv[`EVT_SEC_BIT];
                            wOk = 1'b1;
                        end
                        // match words
                        if (wa == `OFF_SMR_BASE + 12'(i*4)) begin
                            // only the implemented low bits are stored
                            state_d.matchVal[i] = wv[`SID_W-1:0];
                            wOk = 1'b1;
                        end
                    end
                    // group-wide enable and secure observation
                    if (wa == `OFF_CTRL) begin
                        state_d.enable = wv[`CTRL_EN_BIT];
                        state_d.secObs = wv[`CTRL_SECOBS_BIT];
                        wOk = 1'b1;
                    end
                    if (wa == `OFF_CAP) wOk = 1'b1; // read-only, write ignored
                    // an unmapped word answers with an error and changes nothing
                    state_d.bresp = wOk ? `RESP_OKAY : `RESP_SLVERR;
                    state_d.bvalid = 1'b1;
                    state_d.awTaken = 1'b0;
                    state_d.wTaken = 1'b0;
                    state_d.wrSt = WR_RESP;
                end
            end
            // response stands until the master takes it
            WR_RESP: begin
                if (s_axi_bready) begin
                    state_d.bvalid = 1'b0;
                    state_d.wrSt = WR_HOLD;
                end
            end
            WR_HOLD: begin
                // reopen both channels one cycle after the response
                state_d.awready = 1'b1;
                state_d.wready = 1'b1;
                state_d.wrSt = WR_IDLE;
            end
            // unreachable code falls back to idle; with one-hot codes only
            // a flipped flop can bring the machine here
            default: begin
                state_d.wrSt = WR_IDLE;
            end
        endcase

        // read channel: one cycle from address to data
        // the answer is captured at the take, so a counter that steps while
        // rvalid waits for rready is not seen until the next read
        if (state_q.rvalid) begin
            if (s_axi_rready) begin
                state_d.rvalid = 1'b0;
                state_d.arready = 1'b1;
            end
        end else if (s_axi_arvalid && state_q.arready) begin
            // fresh address: decode and capture in one step
            ra = s_axi_araddr;
            for (int i = 0; i < `NUM_CTR; i++) begin
                if (ra == `OFF_CTR_BASE + 12'(i*4)) begin
                    rd = state_q.ctr[i];
                    rOk = 1'b1;
                end
                // event type word reads back only the id, span and namespace fields
                if (ra == `OFF_EVT_BASE + 12'(i*4)) begin
                    rd[`EVT_ID_LSB +: `EVT_W] = state_q.evtId[i];
                    rd[`EVT_SPAN_BIT] = state_q.span[i];
                    rd[`EVT_SEC_BIT] = state_q.secSel[i];
                    rOk = 1'b1;
                end
                // match word reads back only the implemented bits
                if (ra == `OFF_SMR_BASE + 12'(i*4)) begin
                    rd[`SID_W-1:0] = state_q.matchVal[i];
                    rOk = 1'b1;
                end
            end

            // capability word: only the filter-type bit is populated
            if (ra == `OFF_CAP) begin
                rd[`CAP_FILT_BIT] = `FILTER_SHARED;
                rOk = 1'b1;
            end
            if (ra == `OFF_CTRL) begin
                rd[`CTRL_EN_BIT] = state_q.enable;
                rd[`CTRL_SECOBS_BIT] = state_q.secObs;
                rOk = 1'b1;
            end

            // unmapped reads return zero data with an error
            state_d.rdata = rd;
            state_d.rresp = rOk ? `RESP_OKAY : `RESP_SLVERR;
            state_d.rvalid = 1'b1;
            state_d.arready = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // synchronous reset; counters, filters and enables all come up zero,
    // so nothing counts until software sets the enable bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= '0;
            // the bus comes out of reset ready to accept
            state_q.wrSt <= WR_IDLE;
            state_q.awready <= 1'b1;
            state_q.wready <= 1'b1;
            state_q.arready <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from flops; no combinational path from any input
    // reaches a bus output, which keeps timing on the interconnect side easy
    assign s_axi_awready = state_q.awready;
    assign s_axi_wready = state_q.wready;
    assign s_axi_bvalid = state_q.bvalid;
    assign s_axi_bresp = state_q.bresp;
    assign s_axi_arready = state_q.arready;
    assign s_axi_rvalid = state_q.rvalid;
    assign s_axi_rdata = state_q.rdata;
    assign s_axi_rresp = state_q.rresp;

endmodule : perf_counter_stream_filter
`default_nettype wire

// >>> verilog/sid_filter_defines.svh
// Purpose: constants for the counter group stream filter
// Assumes: 32-bit AXI4-Lite register access, word aligned
// Notes:   byte offsets of the register map and field positions
`ifndef SID_FILTER_DEFINES_SVH
`define SID_FILTER_DEFINES_SVH

`define NUM_CTR          4
`define CTR_IDX_W        2
`define SID_W            16
`define FULL_SID_W       24
`define EVT_W            4
`define CTR_W            32

`define OFF_CTR_BASE     12'h000
`define OFF_EVT_BASE     12'h400
`define OFF_SMR_BASE     12'ha00
`define OFF_CAP          12'he00
`define OFF_CTRL         12'he04

`define EVT_ID_LSB       0
`define EVT_SPAN_BIT     29
`define EVT_SEC_BIT      30
`define CAP_FILT_BIT     23
`define CTRL_EN_BIT      0
`define CTRL_SECOBS_BIT  1

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define FILTER_SHARED    1'h0
`define COUNT_TERMINATED 1'h1
`define COUNT_SPECUL     1'h1
`define COUNT_ATOP       1'h0
`define COUNT_CMAINT     1'h0
`define RECOUNT_RETRY    1'h1
`define COMBINED_CACHE   1'h1

`endif

// >>> verilog/sid_filter_pkg.sv
// Purpose: types for the counter group stream filter
// Assumes: constants come from sid_filter_defines.svh
// Notes:   register and bus state types only
`default_nettype none
`include "sid_filter_defines.svh"
package sid_filter_pkg;

    typedef enum logic [2:0] {
        WR_IDLE = 3'h1,
        WR_RESP = 3'h2,
        WR_HOLD = 3'h4
    } wrState_t;

    typedef logic [`CTR_W-1:0] ctrArr_t [`NUM_CTR];

    typedef struct packed {
        logic [`NUM_CTR-1:0][`CTR_W-1:0] ctr;
        logic [`NUM_CTR-1:0][`EVT_W-1:0] evtId;
        logic [`NUM_CTR-1:0]             span;
        logic [`NUM_CTR-1:0]             secSel;
        logic [`NUM_CTR-1:0][`SID_W-1:0] matchVal;
        logic                            enable;
        logic                            secObs;
        wrState_t                        wrSt;
        logic                            awTaken;
        logic                            wTaken;
        logic [11:0]                     awAddr;
        logic [31:0]                     wData;
        logic [3:0]                      wStrb;
        logic                            awready;
        logic                            wready;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            arready;
        logic                            rvalid;
        logic [31:0]                     rdata;
        logic [1:0]                      rresp;
    } state_t;

endpackage : sid_filter_pkg
`default_nettype wire
